/* File: rtl/rpr_pkg.sv */
/*
  Shared constants of the region protection registers and their controller.
  Assumes one 100 MHz clock pclk and an active-low asynchronous presetn.
*/
// Contract
// R1: Info register reports zero instruction regions.
// R2: Info data region count reads eight.
// R3: Info split-map flag reads zero, unified map.
// R4: Enabled, no background: unmatched access faults.
// R5: Background bit: default map, lowest priority.
// R6: Unit disabled: background bit ignored.
// R7: Top-priority handlers bypass checking unless enabled.
// R8: Software never sets handler bit without enable.
// R9: Background on: unprivileged miss faults.
// R10: System space execute-never, strongly ordered always.
// R11: Unit disabled: default map for everyone.
// R12: Enabled: system space, vector table allowed.
// R13: Software enables a region unless background set.
// R14: Region select picks region, values 0-7.
// R15: Base write, valid set: select and update.
// R16: Base write, valid clear: update selected region.
// R17: Base valid bit reads zero.
// R18: Base region field reads current selection.
// R19: Software aligns base to region size.
// R20: Size 4 GB covers whole map from zero.
// R21: Base bits 31 down to log2 size.
// R22: Size is two to size+1, minimum 4.
// R23: Reserved bits zero; aliases share primary storage.
package rpr_pkg;
  // ****************************************************
  // Device register map
  // ****************************************************
  localparam logic [31:0] RPR_INFO_ADDR = 32'hE000ED90;
  localparam logic [31:0] RPR_CTRL_ADDR = 32'hE000ED94;
  localparam logic [31:0] RPR_SEL_ADDR = 32'hE000ED98;
  localparam logic [31:0] RPR_BASE_ADDR = 32'hE000ED9C;
  localparam logic [31:0] RPR_ATTR_ADDR = 32'hE000EDA0;
  localparam logic [31:0] RPR_BASE_A1_ADDR = 32'hE000EDA4;
  localparam logic [31:0] RPR_ATTR_A1_ADDR = 32'hE000EDA8;
  localparam logic [31:0] RPR_BASE_A2_ADDR = 32'hE000EDAC;
  localparam logic [31:0] RPR_ATTR_A2_ADDR = 32'hE000EDB0;
  localparam logic [31:0] RPR_BASE_A3_ADDR = 32'hE000EDB4;
  localparam logic [31:0] RPR_ATTR_A3_ADDR = 32'hE000EDB8;
  localparam logic [31:0] RPR_INFO_RESET = 32'h00000800;
  localparam logic [2:0] RPR_CTRL_RESET = 3'h0;
  localparam logic [2:0] RPR_SEL_RESET = 3'h0;
  localparam logic [26:0] RPR_BASE_RESET = 27'h0000000;
  localparam logic [31:0] RPR_ATTR_RESET = 32'h00000000;
  // ****************************************************
  // Fields
  // ****************************************************
  localparam int RPR_REGIONS = 8;
  localparam int RPR_CTRL_EN_BIT = 0;
  localparam int RPR_CTRL_HI_BIT = 1;
  localparam int RPR_CTRL_BG_BIT = 2;
  localparam int RPR_BASE_VALID_BIT = 4;
  localparam int RPR_BASE_ADDR_LSB = 5;
  localparam int RPR_ATTR_XN_BIT = 28;
  localparam int RPR_ATTR_EN_BIT = 0;
  localparam int RPR_ATTR_SIZE_LSB = 1;
  localparam logic [31:0] RPR_ATTR_MASK = 32'h173FFF3F;
  localparam logic [4:0] RPR_SIZE_MIN = 5'h04;
  localparam logic [4:0] RPR_SIZE_4G = 5'h1F;
  localparam logic [31:0] RPR_SCS_BASE = 32'hE000E000;
  localparam logic [31:0] RPR_SCS_MASK = 32'hFFFFF000;
  localparam logic [31:0] RPR_VEC_BASE = 32'h00000000;
  localparam logic [31:0] RPR_VEC_MASK = 32'hFFFFFC00;
  // ****************************************************
  // Controller APB map
  // ****************************************************
  localparam logic [11:0] RPR_H_ADDR = 12'h000;
  localparam logic [11:0] RPR_H_WDATA = 12'h004;
  localparam logic [11:0] RPR_H_CMD = 12'h008;
  localparam logic [11:0] RPR_H_STATUS = 12'h00C;
  localparam logic [11:0] RPR_H_RDATA = 12'h010;
  localparam logic [11:0] RPR_H_CHK_ADDR = 12'h014;
  localparam logic [11:0] RPR_H_CHK_CMD = 12'h018;
  localparam logic [11:0] RPR_H_CHK_RES = 12'h01C;
  localparam int RPR_CMD_GO_BIT = 0;
  localparam int RPR_CMD_WR_BIT = 1;
  localparam int RPR_CMD_BE_LSB = 4;
  localparam int RPR_CHK_PRIV_BIT = 1;
  localparam int RPR_CHK_FETCH_BIT = 2;
  localparam int RPR_CHK_HI_BIT = 3;
endpackage

/* File: rtl/rpr_if.sv */
/*
  Link between the protection registers and the core side.
  Assumes both ends run on pclk; the bench connects them.
*/
`timescale 1ns/100ps
interface rpr_if;
  // Register access
  logic req;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic ack;
  logic [31:0] rdata;
  // Access check
  logic chk_req;
  logic [31:0] chk_addr;
  logic chk_priv;
  logic chk_fetch;
  logic chk_high;
  logic chk_ack;
  logic chk_fault;
  logic chk_xn;
  logic chk_strong;
  logic chk_hit;
  logic [2:0] chk_region;
  logic chk_bg;
  modport dev (
    input req, wr, addr, wdata, be, chk_req, chk_addr, chk_priv,
    input chk_fetch, chk_high,
    output ack, rdata, chk_ack, chk_fault, chk_xn, chk_strong,
    output chk_hit, chk_region, chk_bg
  );
  modport core (
    output req, wr, addr, wdata, be, chk_req, chk_addr, chk_priv,
    output chk_fetch, chk_high,
    input ack, rdata, chk_ack, chk_fault, chk_xn, chk_strong,
    input chk_hit, chk_region, chk_bg
  );
endinterface

/* File: rtl/rpr_unit.sv */
/*
  Protection unit: control, region registers and access check.
  Assumes the core holds each request until acknowledged.
*/
// Local design decision: register access over APB.
`timescale 1ns/100ps
module rpr_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Core link
  rpr_if.dev bus,
  // Status
  output logic unit_on,
  output logic [rpr_pkg::RPR_REGIONS-1:0] region_on
);
  import rpr_pkg::*;

  // ****************************************************
  // Storage and decode
  // ****************************************************
  logic [2:0] ctrl_q;
  logic [2:0] sel_q;
  logic [26:0] base_q [RPR_REGIONS];
  logic [31:0] attr_q [RPR_REGIONS];
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic act;
  logic is_base;
  logic is_attr;
  logic [31:0] base_img;
  logic [31:0] base_new;
  logic [31:0] attr_new;
  logic [2:0] tgt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign act = ce & bus.req & ~ack_q;
  // Aliases reach the same storage
  assign is_base = bus.addr == RPR_BASE_ADDR ||
                   bus.addr == RPR_BASE_A1_ADDR ||
                   bus.addr == RPR_BASE_A2_ADDR ||
                   bus.addr == RPR_BASE_A3_ADDR; // R23
  assign is_attr = bus.addr == RPR_ATTR_ADDR ||
                   bus.addr == RPR_ATTR_A1_ADDR ||
                   bus.addr == RPR_ATTR_A2_ADDR ||
                   bus.addr == RPR_ATTR_A3_ADDR; // R23
  assign base_img = {base_q[sel_q], 2'b00, sel_q}; // R17 R18
  assign base_new = merge(base_img, bus.wdata, bus.be);
  assign attr_new = merge(attr_q[sel_q], bus.wdata, bus.be) & RPR_ATTR_MASK;
  // Valid bit picks the written region, else current one
  assign tgt = base_new[RPR_BASE_VALID_BIT] ? base_new[2:0] : sel_q; // R15 R16

  // ****************************************************
  // Control and selection
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= RPR_CTRL_RESET;
    end
    else if (act && bus.wr && bus.addr == RPR_CTRL_ADDR)
    begin
      ctrl_q <= 3'(merge({29'h0, ctrl_q}, bus.wdata, bus.be)); // R23
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= RPR_SEL_RESET;
    end
    else if (act && bus.wr && bus.addr == RPR_SEL_ADDR)
    begin
      sel_q <= 3'(merge({29'h0, sel_q}, bus.wdata, bus.be)); // R14
    end
    else if (act && bus.wr && is_base && base_new[RPR_BASE_VALID_BIT])
    begin
      sel_q <= base_new[2:0]; // R15
    end
  end

  // ****************************************************
  // Region storage
  // ****************************************************
  logic [RPR_REGIONS-1:0] hit;
  logic [RPR_REGIONS-1:0] reg_xn;

  for (genvar i = 0; i < RPR_REGIONS; i++)
  begin : g_reg
    logic [4:0] size;
    logic [31:0] mask;
    assign size = attr_q[i][RPR_ATTR_SIZE_LSB +: 5];
    // Low bits below log2 size ignored; 4 GB ignores the base
    assign mask = (size == RPR_SIZE_4G) ? 32'h00000000 :
                  (32'hFFFFFFFF << (size + 5'h01)); // R20 R21 R22
    assign hit[i] = attr_q[i][RPR_ATTR_EN_BIT] && size >= RPR_SIZE_MIN &&
                    ((bus.chk_addr ^ {base_q[i], 5'h00}) & mask) == 0;
    assign reg_xn[i] = attr_q[i][RPR_ATTR_XN_BIT];
    assign region_on[i] = attr_q[i][RPR_ATTR_EN_BIT];

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        base_q[i] <= RPR_BASE_RESET;
      end
      else if (act && bus.wr && is_base && tgt == 3'(i))
      begin
        base_q[i] <= base_new[31:RPR_BASE_ADDR_LSB]; // R15 R16
      end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        attr_q[i] <= RPR_ATTR_RESET;
      end
      else if (act && bus.wr && is_attr && sel_q == 3'(i))
      begin
        attr_q[i] <= attr_new; // R14 R23
      end
    end
  end

  // ****************************************************
  // Register read and answer
  // ****************************************************
  always_comb
  begin
    rdata_d = 32'h00000000; // R23
    if (bus.addr == RPR_INFO_ADDR)
    begin
      rdata_d = RPR_INFO_RESET; // R1 R2 R3
    end
    else if (bus.addr == RPR_CTRL_ADDR)
    begin
      rdata_d = {29'h0, ctrl_q};
    end
    else if (bus.addr == RPR_SEL_ADDR)
    begin
      rdata_d = {29'h0, sel_q}; // R14
    end
    else if (is_base)
    begin
      rdata_d = base_img; // R17 R18
    end
    else if (is_attr)
    begin
      rdata_d = attr_q[sel_q];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      ack_q <= bus.req & ~ack_q;
      if (act && !bus.wr)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ****************************************************
  // Access check
  // ****************************************************
  logic chk_ack_q;
  logic fault_q;
  logic xn_q;
  logic strong_q;
  logic hit_q;
  logic [2:0] region_q;
  logic bg_q;
  logic any_hit;
  logic [2:0] top;
  logic scs;
  logic special;
  logic active;
  logic bg_use;
  logic fault_d;

  always_comb
  begin
    top = 3'h0;
    for (int k = 0; k < RPR_REGIONS; k++)
    begin
      if (hit[k])
      begin
        top = 3'(k);
      end
    end
  end

  assign any_hit = |hit;
  assign scs = (bus.chk_addr & RPR_SCS_MASK) == RPR_SCS_BASE;
  assign special = scs || (bus.chk_addr & RPR_VEC_MASK) == RPR_VEC_BASE;
  // Handlers at -1/-2 bypass unless handler bit set
  assign active = ctrl_q[RPR_CTRL_EN_BIT] &&
                  (!bus.chk_high || ctrl_q[RPR_CTRL_HI_BIT]); // R7 R11
  // Background only counts while active and privileged
  assign bg_use = active && ctrl_q[RPR_CTRL_BG_BIT] && bus.chk_priv &&
                  !any_hit; // R5 R6 R9

  always_comb
  begin
    fault_d = 1'b0;
    if (bus.chk_fetch && scs)
    begin
      fault_d = 1'b1; // R10
    end
    else if (active && !special)
    begin
      if (any_hit)
      begin
        fault_d = bus.chk_fetch && reg_xn[top]; // R5
      end
      else
      begin
        fault_d = !bg_use; // R4 R9
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chk_ack_q <= 1'b0;
      fault_q <= 1'b0;
      xn_q <= 1'b0;
      strong_q <= 1'b0;
      hit_q <= 1'b0;
      region_q <= 3'h0;
      bg_q <= 1'b0;
    end
    else if (ce)
    begin
      chk_ack_q <= bus.chk_req & ~chk_ack_q;
      if (bus.chk_req && !chk_ack_q)
      begin
        fault_q <= fault_d; // R12
        xn_q <= scs || (active && any_hit && reg_xn[top]); // R10
        strong_q <= scs; // R10
        hit_q <= active && any_hit;
        region_q <= top;
        bg_q <= bg_use; // R5
      end
    end
  end

  assign bus.ack = ack_q;
  assign bus.rdata = rdata_q;
  assign bus.chk_ack = chk_ack_q;
  assign bus.chk_fault = fault_q;
  assign bus.chk_xn = xn_q;
  assign bus.chk_strong = strong_q;
  assign bus.chk_hit = hit_q;
  assign bus.chk_region = region_q;
  assign bus.chk_bg = bg_q;
  assign unit_on = ctrl_q[RPR_CTRL_EN_BIT];
endmodule

/* File: rtl/rpr_ctl.sv */
/*
  Core-side controller: APB slave issuing register and check requests.
  Assumes an APB master on pclk and the unit on the other link end.
*/
`timescale 1ns/100ps
module rpr_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Unit link
  rpr_if.core bus
);
  import rpr_pkg::*;

  // ****************************************************
  // APB slave
  // ****************************************************
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic err_d;
  logic wr_en;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic req_q;
  logic wr_q;
  logic [3:0] be_q;
  logic [31:0] out_q;
  logic done_q;
  logic [31:0] caddr_q;
  logic chk_q;
  logic priv_q;
  logic fetch_q;
  logic high_q;
  logic cdone_q;
  logic [7:0] res_q;

  assign wr_en = ce && psel && penable && pready_q && pwrite && !pslverr_q;

  always_comb
  begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    unique case (paddr[11:0])
      RPR_H_ADDR: rd_d = addr_q;
      RPR_H_WDATA: rd_d = wdata_q;
      RPR_H_CMD: rd_d = {24'h0, be_q, 2'b00, wr_q, 1'b0};
      RPR_H_STATUS: rd_d = {28'h0, cdone_q, chk_q, done_q, req_q};
      RPR_H_RDATA: rd_d = rdata_q;
      RPR_H_CHK_ADDR: rd_d = caddr_q;
      RPR_H_CHK_CMD: rd_d = {28'h0, high_q, fetch_q, priv_q, 1'b0};
      RPR_H_CHK_RES: rd_d = {24'h0, res_q};
      default: err_d = 1'b1;
    endcase
    if (paddr[31:12] != 20'h00000)
    begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else if (ce)
    begin
      pready_q <= psel && !penable;
      if (psel && !penable)
      begin
        prdata_q <= (pwrite || err_d) ? 32'h00000000 : rd_d;
        pslverr_q <= err_d;
      end
    end
  end

  // ****************************************************
  // Register request
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
    end
    else if (wr_en && !req_q)
    begin
      if (paddr[11:0] == RPR_H_ADDR)
      begin
        addr_q <= pwdata;
      end
      if (paddr[11:0] == RPR_H_WDATA)
      begin
        wdata_q <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_q <= 1'b0;
      wr_q <= 1'b0;
      be_q <= 4'h0;
      out_q <= 32'h00000000;
      done_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      if (req_q && bus.ack)
      begin
        req_q <= 1'b0;
        done_q <= 1'b1;
        rdata_q <= wr_q ? rdata_q : bus.rdata;
      end
      else if (wr_en && !req_q && paddr[11:0] == RPR_H_CMD &&
               pwdata[RPR_CMD_GO_BIT])
      begin
        req_q <= 1'b1;
        done_q <= 1'b0;
        wr_q <= pwdata[RPR_CMD_WR_BIT];
        be_q <= pwdata[RPR_CMD_BE_LSB +: 4];
        out_q <= wdata_q;
        // Handler bit dropped when enable stays clear
        if (addr_q == RPR_CTRL_ADDR && !wdata_q[RPR_CTRL_EN_BIT])
        begin
          out_q[RPR_CTRL_HI_BIT] <= 1'b0; // R8
        end
      end
    end
  end

  // ****************************************************
  // Check request
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      caddr_q <= 32'h00000000;
      chk_q <= 1'b0;
      priv_q <= 1'b0;
      fetch_q <= 1'b0;
      high_q <= 1'b0;
      cdone_q <= 1'b0;
      res_q <= 8'h00;
    end
    else if (ce)
    begin
      if (chk_q && bus.chk_ack)
      begin
        chk_q <= 1'b0;
        cdone_q <= 1'b1;
        res_q <= {bus.chk_bg, bus.chk_region, bus.chk_hit,
                  bus.chk_strong, bus.chk_xn, bus.chk_fault};
      end
      else if (wr_en && !chk_q && paddr[11:0] == RPR_H_CHK_ADDR)
      begin
        caddr_q <= pwdata;
      end
      else if (wr_en && !chk_q && paddr[11:0] == RPR_H_CHK_CMD)
      begin
        chk_q <= pwdata[RPR_CMD_GO_BIT];
        cdone_q <= cdone_q & ~pwdata[RPR_CMD_GO_BIT];
        priv_q <= pwdata[RPR_CHK_PRIV_BIT];
        fetch_q <= pwdata[RPR_CHK_FETCH_BIT];
        high_q <= pwdata[RPR_CHK_HI_BIT];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bus.req = req_q;
  assign bus.wr = wr_q;
  assign bus.addr = addr_q;
  assign bus.wdata = out_q;
  assign bus.be = be_q;
  assign bus.chk_req = chk_q;
  assign bus.chk_addr = caddr_q;
  assign bus.chk_priv = priv_q;
  assign bus.chk_fetch = fetch_q;
  assign bus.chk_high = high_q;
endmodule

/* File: test/rpr_assertions.sv */
/*
  Checker on the link between unit and controller.
  Assumes plain inputs tied to the link signals, pclk and presetn.
*/
`timescale 1ns/100ps
module rpr_assertions (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register link
  input wire logic wr,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic ack,
  input wire logic [31:0] rdata,
  // Check link
  input wire logic [31:0] chk_addr,
  input wire logic chk_priv,
  input wire logic chk_fetch,
  input wire logic chk_high,
  input wire logic chk_ack,
  input wire logic chk_fault,
  input wire logic chk_xn,
  input wire logic chk_strong,
  input wire logic chk_hit,
  input wire logic chk_bg
);
  import rpr_pkg::*;
  logic [2:0] sel_q;
  logic [2:0] ctl_q;
  logic wr_done, is_base, scs, vec, live;
  assign wr_done = ack && wr && be[0];
  assign is_base = addr inside {RPR_BASE_ADDR, RPR_BASE_A1_ADDR,
    RPR_BASE_A2_ADDR, RPR_BASE_A3_ADDR};
  assign scs = (chk_addr & RPR_SCS_MASK) == RPR_SCS_BASE;
  assign vec = (chk_addr & RPR_VEC_MASK) == RPR_VEC_BASE;
  assign live = ctl_q[0] && (!chk_high || ctl_q[1]) && !scs && !vec;
  // ****************************
  // Shadow of selection, control
  // ****************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sel_q <= 3'h0;
    else if (wr_done && (addr == RPR_SEL_ADDR || (is_base && wdata[4])))
      sel_q <= wdata[2:0];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctl_q <= 3'h0;
    else if (wr_done && addr == RPR_CTRL_ADDR)
      ctl_q <= wdata[2:0];
  end
  // ****************************
  // Properties
  // ****************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_info;
    ack && !wr && addr == RPR_INFO_ADDR |-> rdata == RPR_INFO_RESET;
  endproperty
  a_info: assert property (p_info) else $error("info word wrong");
  property p_base_low;
    ack && !wr && is_base |-> rdata[4:0] == {2'b00, sel_q};
  endproperty
  a_base_low: assert property (p_base_low)
    else $error("base low bits");
  property p_sel;
    ack && !wr && addr == RPR_SEL_ADDR |-> rdata == {29'h0, sel_q};
  endproperty
  a_sel: assert property (p_sel) else $error("select wrong");
  property p_ctrl;
    ack && !wr && addr == RPR_CTRL_ADDR |-> rdata == {29'h0, ctl_q};
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control wrong");
  property p_off;
    chk_ack && !ctl_q[0] && !(chk_fetch && scs) |-> !chk_fault && !chk_bg;
  endproperty
  a_off: assert property (p_off) else $error("fault while off");
  property p_handler;
    chk_ack && ctl_q[0] && !ctl_q[1] && chk_high && !(chk_fetch && scs)
      |-> !chk_fault;
  endproperty
  a_handler: assert property (p_handler) else $error("handler fault");
  property p_scs;
    chk_ack && scs |-> chk_xn && chk_strong;
  endproperty
  a_scs: assert property (p_scs) else $error("system space attrs");
  property p_sys;
    chk_ack && ctl_q[0] && (scs || vec) && !chk_fetch |-> !chk_fault;
  endproperty
  a_sys: assert property (p_sys) else $error("system access fault");
  property p_miss;
    chk_ack && live && !chk_hit |-> chk_fault == !(ctl_q[2] && chk_priv);
  endproperty
  a_miss: assert property (p_miss) else $error("miss outcome");
  property p_hit_first;
    chk_ack && live && chk_hit
      |-> !chk_bg && chk_fault == (chk_fetch && chk_xn);
  endproperty
  a_hit_first: assert property (p_hit_first) else $error("hit used bg");
endmodule

/* File: test/region_protect_regs_tb.sv */
/*
  Bench for unit and controller joined by the link.
  Assumes APB on pclk at 100 MHz and the shared package.
*/
`timescale 1ns/100ps
module region_protect_regs_tb;
  import rpr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, unit_on, last_err;
  logic [7:0] region_on;
  int err_total = 0;
  int num_checks = 0;
  rpr_if u_rpr_if ();
  rpr_unit u_rpr_unit (.pclk(pclk), .presetn(presetn), .ce(ce),
    .bus(u_rpr_if), .unit_on(unit_on), .region_on(region_on));
  rpr_ctl u_rpr_ctl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(u_rpr_if));
  rpr_assertions u_rpr_assertions (.pclk(pclk), .presetn(presetn),
    .wr(u_rpr_if.wr), .addr(u_rpr_if.addr), .wdata(u_rpr_if.wdata),
    .be(u_rpr_if.be), .ack(u_rpr_if.ack), .rdata(u_rpr_if.rdata),
    .chk_addr(u_rpr_if.chk_addr), .chk_priv(u_rpr_if.chk_priv),
    .chk_fetch(u_rpr_if.chk_fetch), .chk_high(u_rpr_if.chk_high),
    .chk_ack(u_rpr_if.chk_ack), .chk_fault(u_rpr_if.chk_fault),
    .chk_xn(u_rpr_if.chk_xn), .chk_strong(u_rpr_if.chk_strong),
    .chk_hit(u_rpr_if.chk_hit), .chk_bg(u_rpr_if.chk_bg));
  always #5 pclk = ~pclk;
  // ****************************
  // Shared tasks
  // ****************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      err_total++;
      conclude();
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input int b);
    logic [31:0] s;
    int n;
    s = 32'h0;
    n = 0;
    while (s[b] !== 1'b1 && n < 20)
    begin
      apb(1'b0, 32'(RPR_H_STATUS), 32'h0, s);
      n++;
    end
    if (n >= 20)
    begin
      err_total++;
      conclude();
    end
  endtask
  task automatic dev(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic [31:0] s;
    apb(1'b1, 32'(RPR_H_ADDR), a, s);
    apb(1'b1, 32'(RPR_H_WDATA), d, s);
    apb(1'b1, 32'(RPR_H_CMD), {24'h0, 4'hF, 2'b00, w, 1'b1}, s);
    poll(1);
    apb(1'b0, 32'(RPR_H_RDATA), 32'h0, q);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    dev(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    dev(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task automatic setreg(input logic [31:0] r, input logic [31:0] b,
                        input logic [31:0] at);
    wr(RPR_SEL_ADDR, r);
    wr(RPR_BASE_ADDR, b);
    wr(RPR_ATTR_ADDR, at);
  endtask
  task automatic chk_case(input logic [31:0] a, input logic [2:0] hfp,
                          input logic [7:0] e, input logic [7:0] m);
    logic [31:0] s;
    apb(1'b1, 32'(RPR_H_CHK_ADDR), a, s);
    apb(1'b1, 32'(RPR_H_CHK_CMD), {28'h0, hfp, 1'b1}, s);
    poll(3);
    apb(1'b0, 32'(RPR_H_CHK_RES), 32'h0, s);
    check(s & {24'h0, m}, {24'h0, e & m});
  endtask
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_reset();
    logic [31:0] q;
    check({23'h0, unit_on, region_on}, 32'h0);
    for (int i = 0; i < 11; i++)
      rdc(RPR_INFO_ADDR + 32'(4 * i),
          i == 0 ? RPR_INFO_RESET : 32'h0);
    rdc(32'hE000EDBC, 32'h0);
    apb(1'b0, 32'h00001000, 32'h0, q);
    check({31'h0, last_err}, 32'h1);
    apb(1'b1, 32'h00001004, 32'hFFFFFFFF, q);
    check({31'h0, last_err}, 32'h1);
    apb(1'b0, 32'(RPR_H_WDATA), 32'h0, q);
    check(q, 32'h0);
  endtask
  task automatic t_select();
    wr(RPR_SEL_ADDR, 32'h2);
    rdc(RPR_SEL_ADDR, 32'h2);
    wr(RPR_BASE_ADDR, 32'h00010016);
    rdc(RPR_SEL_ADDR, 32'h6);
    rdc(RPR_BASE_ADDR, 32'h00010006);
    wr(RPR_BASE_A2_ADDR, 32'h00020003);
    rdc(RPR_SEL_ADDR, 32'h6);
    rdc(RPR_BASE_A3_ADDR, 32'h00020006);
    wr(RPR_ATTR_A1_ADDR, 32'hFFFFFFFF);
    rdc(RPR_ATTR_ADDR, RPR_ATTR_MASK);
    check({24'h0, region_on}, 32'h40);
    wr(RPR_CTRL_ADDR, 32'hFFFFFFFF);
    rdc(RPR_CTRL_ADDR, 32'h7);
    wr(RPR_CTRL_ADDR, 32'h2);
    rdc(RPR_CTRL_ADDR, 32'h0);
  endtask
  task automatic t_checks();
    setreg(32'h6, 32'h20000000, 32'h13);
    chk_case(32'h20000000, 3'b000, 8'h00, 8'h87);
    wr(RPR_CTRL_ADDR, 32'h4);
    chk_case(32'h30000000, 3'b001, 8'h00, 8'h87);
    chk_case(32'hE000E010, 3'b010, 8'h07, 8'h87);
    wr(RPR_CTRL_ADDR, 32'h1);
    check({31'h0, unit_on}, 32'h1);
    chk_case(32'h20000100, 3'b000, 8'h68, 8'hFF);
    chk_case(32'h30000000, 3'b001, 8'h01, 8'h8F);
    chk_case(32'hE000E010, 3'b000, 8'h06, 8'h87);
    chk_case(32'h00000100, 3'b000, 8'h00, 8'h87);
    chk_case(32'h30000000, 3'b101, 8'h00, 8'h87);
    wr(RPR_CTRL_ADDR, 32'h3);
    chk_case(32'h30000000, 3'b101, 8'h01, 8'h8F);
    wr(RPR_CTRL_ADDR, 32'h5);
    chk_case(32'h30000000, 3'b001, 8'h80, 8'h8F);
    chk_case(32'h30000000, 3'b000, 8'h01, 8'h8F);
    chk_case(32'h20000100, 3'b001, 8'h68, 8'hFF);
    wr(RPR_CTRL_ADDR, 32'h1);
    setreg(32'h5, 32'h30000000, 32'h07);
    chk_case(32'h30000000, 3'b000, 8'h01, 8'h8F);
    setreg(32'h5, 32'h30000000, 32'h09);
    chk_case(32'h3000001F, 3'b000, 8'h58, 8'hFF);
    chk_case(32'h30000020, 3'b000, 8'h01, 8'h8F);
    setreg(32'h7, 32'h40000000, 32'h3F);
    chk_case(32'h30000000, 3'b000, 8'h78, 8'hFF);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_select();
    t_checks();
    conclude();
  end
endmodule
